// ---- pkg/prt_pkg.sv ----
// Constants and state encoding of the push-button reset timer.
package prt_pkg;

    // ------------------------------------------------------------------
    // Clock and timebase
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_PERIOD_NS = 1000;
    // One timebase tick is one microsecond; rounded up so a tick is never short.
    localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICKS_PER_S = 1000000;
    localparam int unsigned TICKS_PER_MS = 1000;

    // ------------------------------------------------------------------
    // Timing figures in their own units, and the derived tick counts
    // ------------------------------------------------------------------
    localparam real HOLD_LONG_S = 12.5;
    localparam real HOLD_SHORT_S = 7.5;
    localparam real HOLD_ZERO_S = 0.0;
    localparam real PULSE_LONG_MS = 400.0;
    localparam real PULSE_SHORT_MS = 80.0;
    localparam int unsigned STARTUP_US = 300;
    localparam int unsigned DETECT_US = 150;
    localparam int unsigned HOLD_LONG_TICKS = int'(HOLD_LONG_S * TICKS_PER_S);
    localparam int unsigned HOLD_SHORT_TICKS = int'(HOLD_SHORT_S * TICKS_PER_S);
    localparam int unsigned HOLD_ZERO_TICKS = int'(HOLD_ZERO_S * TICKS_PER_S);
    localparam int unsigned PULSE_LONG_TICKS = int'(PULSE_LONG_MS * TICKS_PER_MS);
    localparam int unsigned PULSE_SHORT_TICKS = int'(PULSE_SHORT_MS * TICKS_PER_MS);
    localparam int unsigned STARTUP_TICKS = STARTUP_US;
    localparam int unsigned DETECT_TICKS = DETECT_US;
    localparam int unsigned CNT_W = 24;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_COUNT = 12'h008;
    localparam logic [11:0] ADDR_EVENTS = 12'h00c;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_SEL_BIT = 4;
    localparam int unsigned ST_BTN_A_BIT = 5;
    localparam int unsigned ST_BTN_B_BIT = 6;
    localparam int unsigned ST_RST_BIT = 7;
    localparam int unsigned ST_SUPPLY_BIT = 8;
    localparam int unsigned EVT_W = 16;

    // ------------------------------------------------------------------
    // Sequencer states, Gray coded along the usual path
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_STARTUP = 3'h1,
        ST_ARMED = 3'h3,
        ST_HOLD = 3'h2,
        ST_PULSE = 3'h6,
        ST_WAIT_REL = 3'h7
    } prt_state_t;

endpackage : prt_pkg

// ---- pkg/prt_reg_if.sv ----
// Interface carrying control and status between the register slave and the sequencer.
`timescale 1ns/1ps
interface prt_reg_if;
    logic enable;
    logic events_clr;
    logic [31:0] status_word;
    logic [31:0] count_word;
    logic [31:0] events_word;

    modport regs (
        output enable,
        output events_clr,
        input status_word,
        input count_word,
        input events_word
    );

    modport core (
        input enable,
        input events_clr,
        output status_word,
        output count_word,
        output events_word
    );
endinterface : prt_reg_if

// ---- verilog/prt_timebase.sv ----
// Free-running microsecond tick generator.
`timescale 1ns/1ps
module prt_timebase #(
    parameter int unsigned TICK_CYCLES = prt_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    output logic tick
);
    localparam int unsigned DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    logic [DIV_W-1:0] div_reg;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // Free-running, so each timed interval may end up to one tick early.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
            tick <= 1'b0;
        end else if (clk_en) begin
            tick <= (div_reg == DIV_LAST);
            if (div_reg == DIV_LAST) begin
                div_reg <= '0;
            end else begin
                div_reg <= div_reg + 1'b1;
            end
        end
    end
endmodule : prt_timebase

// ---- verilog/prt_apb_regs.sv ----
// APB slave holding the control register and returning the sequencer status words.
`timescale 1ns/1ps
module prt_apb_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    prt_reg_if.regs rif
);
    logic mapped;
    logic [31:0] rdata;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rdata = 32'h0;
        case (paddr)
            prt_pkg::ADDR_CTRL: rdata = {31'h0, rif.enable};
            prt_pkg::ADDR_STATUS: rdata = rif.status_word;
            prt_pkg::ADDR_COUNT: rdata = rif.count_word;
            prt_pkg::ADDR_EVENTS: rdata = rif.events_word;
            default: mapped = 1'b0;
        endcase
    end

    // Answer prepared in setup, so the access phase is one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0 : rdata;
                pslverr <= !mapped;
            end
        end
    end

    // ------------------------------------------------------------------
    // Write side
    // ------------------------------------------------------------------
    // Event clear pulses once on the completing edge of an events register write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rif.enable <= prt_pkg::CTRL_EN_RESET;
            rif.events_clr <= 1'b0;
        end else if (clk_en) begin
            rif.events_clr <= psel && penable && pready && pwrite && (paddr == prt_pkg::ADDR_EVENTS);
            if (psel && penable && pready && pwrite && (paddr == prt_pkg::ADDR_CTRL)) begin
                rif.enable <= pwdata[prt_pkg::CTRL_EN_BIT];
            end
        end
    end
endmodule : prt_apb_regs

// ---- verilog/prt_reset_timer.sv ----
// Push-button reset timer: hold detection, reset pulse, start-up delay and open-drain output.
`timescale 1ns/1ps

// Function
// - Dual channel: both buttons low together, unbroken, for the whole hold time.
// - Level variant: reset ends when either button goes high; no fixed pulse.
// - Pulse variants: reset stays low for the configured pulse length, then releases.
// - Single channel: one button low for the hold time gives a fixed pulse; with LEVEL_MODE set the code holds reset only while that button stays low.
// - The select strap chooses between two build-time hold times.
// - Select is sampled only at start-up or while a button is high.
// - One reset per valid press; holding longer gives no further reset.
// - Dual channel re-arms only after a button goes high.
// - Single channel re-arms only after its button returns high.
// - Fixed pulse length is independent of the buttons.
// - Button glitches during a fixed pulse are ignored entirely.
// - A button high when the pulse ends counts as release and re-arms.
// - Output only pulls low or floats; it never drives high.
// - After supply turns valid, wait the start-up delay before acting.
// - A zero hold time asserts after the short detection delay instead.
// - Pulse length is a build-time option, typically 80 ms or 400 ms.
module prt_reset_timer #(
    parameter int unsigned CHANNELS = 2,
    parameter bit LEVEL_MODE = 1'b0,
    parameter int unsigned HOLD_SEL_HIGH_TICKS = prt_pkg::HOLD_ZERO_TICKS,
    parameter int unsigned HOLD_SEL_LOW_TICKS = prt_pkg::HOLD_SHORT_TICKS,
    parameter int unsigned PULSE_TICKS = prt_pkg::PULSE_LONG_TICKS,
    parameter int unsigned STARTUP_TICKS = prt_pkg::STARTUP_TICKS,
    parameter int unsigned DETECT_TICKS = prt_pkg::DETECT_TICKS,
    parameter int unsigned TICK_CYCLES = prt_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic supply_valid,
    input wire logic button_in_a,
    input wire logic button_in_b,
    input wire logic hold_time_select,
    output logic reset_out,
    output logic reset_oe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam int unsigned CW = prt_pkg::CNT_W;
    localparam int unsigned EW = prt_pkg::EVT_W;
    localparam logic [CW-1:0] HOLD_HIGH = CW'(HOLD_SEL_HIGH_TICKS);
    localparam logic [CW-1:0] HOLD_LOW = CW'(HOLD_SEL_LOW_TICKS);
    localparam logic [CW-1:0] PULSE_LEN = CW'(PULSE_TICKS);
    localparam logic [CW-1:0] STARTUP_LEN = CW'(STARTUP_TICKS);
    localparam logic [CW-1:0] DETECT_LEN = CW'(DETECT_TICKS);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True when the tick now arriving completes an interval of the given length.
    function automatic logic span_done(input logic [CW-1:0] cnt, input logic [CW-1:0] len);
        logic [CW:0] nxt;
        nxt = {1'b0, cnt} + 1'b1;
        return (len == '0) || (nxt >= {1'b0, len});
    endfunction : span_done

    prt_reg_if rif ();
    prt_pkg::prt_state_t state_reg;
    prt_pkg::prt_state_t state_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic sel_reg;
    logic [EW-1:0] events_reg;
    logic tick;
    logic run;
    logic pressed;
    logic [CW-1:0] hold_len;
    logic start_pulse;

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    prt_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .tick(tick)
    );

    prt_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rif(rif.regs)
    );

    // ------------------------------------------------------------------
    // Input qualification
    // ------------------------------------------------------------------
    // The enable bit parks the block as if unpowered.
    assign run = supply_valid && rif.enable;

    // The press condition needs every active channel low at once.
    assign pressed = (CHANNELS > 1) ? (!button_in_a && !button_in_b) : !button_in_a;

    // A zero hold setting is replaced by the short detection delay.
    assign hold_len = ((sel_reg ? HOLD_HIGH : HOLD_LOW) == '0) ? DETECT_LEN
                                                               : (sel_reg ? HOLD_HIGH : HOLD_LOW);

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        start_pulse = 1'b0;
        case (state_reg)
            prt_pkg::ST_OFF: begin
                cnt_next = '0;
                state_next = prt_pkg::ST_STARTUP;
            end
            prt_pkg::ST_STARTUP: begin
                // Buttons are not looked at until the start-up delay has run out.
                if (tick) begin
                    if (span_done(cnt_reg, STARTUP_LEN)) begin
                        state_next = prt_pkg::ST_ARMED;
                        cnt_next = '0;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
            end
            prt_pkg::ST_ARMED: begin
                cnt_next = '0;
                if (pressed) begin
                    state_next = prt_pkg::ST_HOLD;
                end
            end
            prt_pkg::ST_HOLD: begin
                // Any break in the press throws away the time collected so far.
                if (!pressed) begin
                    state_next = prt_pkg::ST_ARMED;
                    cnt_next = '0;
                end else if (tick) begin
                    if (span_done(cnt_reg, hold_len)) begin
                        state_next = prt_pkg::ST_PULSE;
                        start_pulse = 1'b1;
                        cnt_next = '0;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
            end
            prt_pkg::ST_PULSE: begin
                if (LEVEL_MODE) begin
                    // Level variant: the pulse lasts as long as the press does.
                    cnt_next = '0;
                    if (!pressed) begin
                        state_next = prt_pkg::ST_ARMED;
                    end
                end else if (tick) begin
                    // Buttons are not consulted until the fixed length has elapsed.
                    if (span_done(cnt_reg, PULSE_LEN)) begin
                        cnt_next = '0;
                        state_next = pressed ? prt_pkg::ST_WAIT_REL : prt_pkg::ST_ARMED;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
            end
            prt_pkg::ST_WAIT_REL: begin
                // A press held past its reset gives no second one until released.
                cnt_next = '0;
                if (!pressed) begin
                    state_next = prt_pkg::ST_ARMED;
                end
            end
            default: begin
                state_next = prt_pkg::ST_OFF;
                cnt_next = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    // Loss of supply overrides everything and clears the timers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= prt_pkg::ST_OFF;
            cnt_reg <= '0;
        end else if (clk_en) begin
            if (!run) begin
                state_reg <= prt_pkg::ST_OFF;
                cnt_reg <= '0;
            end else begin
                state_reg <= state_next;
                cnt_reg <= cnt_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Hold-time select sample
    // ------------------------------------------------------------------
    // Frozen during a full press, so a strap change cannot retime a hold.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= 1'b0;
        end else if (clk_en) begin
            if (!run) begin
                sel_reg <= 1'b0;
            end else if (state_reg == prt_pkg::ST_STARTUP || !pressed) begin
                sel_reg <= hold_time_select;
            end
        end
    end

    // ------------------------------------------------------------------
    // Open-drain output
    // ------------------------------------------------------------------
    // Data is constant low; only the enable moves, so the pin never drives high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_out <= 1'b0;
            reset_oe <= 1'b0;
        end else if (clk_en) begin
            reset_out <= 1'b0;
            reset_oe <= run && (state_next == prt_pkg::ST_PULSE);
        end
    end

    // ------------------------------------------------------------------
    // Reset event counter
    // ------------------------------------------------------------------
    // A new reset in the clearing cycle wins and leaves a count of one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events_reg <= '0;
        end else if (clk_en) begin
            if (run && start_pulse) begin
                events_reg <= rif.events_clr ? EW'(1) : events_reg + 1'b1;
            end else if (rif.events_clr) begin
                events_reg <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------------
    always_comb begin
        rif.status_word = 32'h0;
        rif.status_word[prt_pkg::ST_STATE_LSB +: 3] = state_reg;
        rif.status_word[prt_pkg::ST_SEL_BIT] = sel_reg;
        rif.status_word[prt_pkg::ST_BTN_A_BIT] = button_in_a;
        rif.status_word[prt_pkg::ST_BTN_B_BIT] = button_in_b;
        rif.status_word[prt_pkg::ST_RST_BIT] = reset_oe;
        rif.status_word[prt_pkg::ST_SUPPLY_BIT] = supply_valid;
        rif.count_word = {{(32 - CW){1'b0}}, cnt_reg};
        rif.events_word = {{(32 - EW){1'b0}}, events_reg};
    end
endmodule : prt_reset_timer

// ---- verification/prt_button_model.sv ----
// Partner model: push buttons, timer strap and the pulled-up reset line.
`timescale 1ns/1ps
module prt_button_model (
    input wire logic pclk,
    input wire logic reset_oe,
    output logic button_in_a,
    output logic button_in_b,
    output logic hold_time_select,
    output logic sys_reset_n
);
    // Buttons idle released and the strap tied high until told otherwise.
    initial begin
        button_in_a = 1'b1;
        button_in_b = 1'b1;
        hold_time_select = 1'b1;
    end
    // The line has a pull-up, so it reads high whenever the timer lets it float.
    assign sys_reset_n = !reset_oe;
    // Buttons move just after a rising edge; low means pressed.
    task automatic press(input logic a, input logic b);
        @(posedge pclk);
        button_in_a <= a;
        button_in_b <= b;
    endtask : press
    // The strap moves only with a button up, unless misuse is wanted.
    task automatic strap(input logic s, input logic misuse);
        @(posedge pclk);
        if (misuse || button_in_a || button_in_b) begin
            hold_time_select <= s;
        end
    endtask : strap
endmodule : prt_button_model

// ---- verification/prt_reset_timer_asserts.sv ----
// Concurrent checks on the push-button reset timer ports.
`timescale 1ns/1ps
module prt_reset_timer_asserts #(
    parameter int unsigned HOLD_SEL_HIGH_TICKS = 5,
    parameter int unsigned HOLD_SEL_LOW_TICKS = 20,
    parameter int unsigned PULSE_TICKS = 8,
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic supply_valid,
    input wire logic button_in_a,
    input wire logic button_in_b,
    input wire logic reset_out,
    input wire logic reset_oe,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr
);
    localparam int unsigned HOLD_MIN =
        (HOLD_SEL_HIGH_TICKS < HOLD_SEL_LOW_TICKS) ? HOLD_SEL_HIGH_TICKS : HOLD_SEL_LOW_TICKS;
    logic [31:0] low_cnt;
    logic [31:0] oe_cnt;
    logic oe_prev;
    logic rel_seen;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Long spans are counted in flops; repetitions cannot reach them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 32'h0;
            oe_cnt <= 32'h0;
            oe_prev <= 1'b0;
            rel_seen <= 1'b1;
        end else if (clk_en) begin
            low_cnt <= (button_in_a || button_in_b) ? 32'h0 : low_cnt + 32'h1;
            oe_cnt <= reset_oe ? oe_cnt + 32'h1 : 32'h0;
            oe_prev <= reset_oe;
            if (reset_oe && !oe_prev) begin
                rel_seen <= 1'b0;
            end else if (button_in_a || button_in_b || !supply_valid) begin
                rel_seen <= 1'b1;
            end
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_supply_lost;
        !supply_valid ##1 !supply_valid;
    endsequence
    a_never_high: assert property (!reset_out)
        else $error("reset data driven high");
    a_off_floats: assert property (s_supply_lost |=> !reset_oe)
        else $error("output active without supply");
    a_startup_quiet: assert property ($rose(supply_valid) |-> !reset_oe [*8])
        else $error("output active in start-up");
    a_hold_length: assert property ($rose(reset_oe) |-> low_cnt >= (HOLD_MIN - 1) * TICK_CYCLES)
        else $error("reset before hold time");
    a_single_shot: assert property ($rose(reset_oe) |-> rel_seen)
        else $error("reset again without release");
    a_pulse_length: assert property ($fell(reset_oe) && $past(supply_valid) |->
        oe_cnt >= (PULSE_TICKS - 1) * TICK_CYCLES && oe_cnt <= (PULSE_TICKS + 1) * TICK_CYCLES + 2)
        else $error("pulse length wrong");
    a_ready_next: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_bad_addr: assert property (s_setup ##0 paddr > 12'h00c |=> pslverr)
        else $error("unmapped address accepted");
endmodule : prt_reset_timer_asserts

bind prt_reset_timer prt_reset_timer_asserts #(
    .HOLD_SEL_HIGH_TICKS(HOLD_SEL_HIGH_TICKS), .HOLD_SEL_LOW_TICKS(HOLD_SEL_LOW_TICKS),
    .PULSE_TICKS(PULSE_TICKS), .TICK_CYCLES(TICK_CYCLES)
) prt_reset_timer_asserts_i (
    .pclk, .presetn, .clk_en, .supply_valid, .button_in_a, .button_in_b, .reset_out, .reset_oe,
    .psel, .penable, .paddr, .pready, .pslverr
);

// ---- verification/tb_prt_reset_timer.sv ----
// Self-checking bench for the push-button reset timer.
`timescale 1ns/1ps
module tb_prt_reset_timer;
    localparam int TC = 4;
    localparam int HI = 5;
    localparam int LO = 20;
    localparam int PL = 8;
    localparam logic [31:0] w1 = 32'h1;
    localparam logic [31:0] w0 = 32'h0;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic supply_valid = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, reset_out, reset_oe, sys_reset_n;
    logic button_in_a, button_in_b, hold_time_select;
    int n_mismatch = 0;
    int tests_run = 0;
    int t;
    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;
    prt_reset_timer #(
        .HOLD_SEL_HIGH_TICKS(HI), .HOLD_SEL_LOW_TICKS(LO), .PULSE_TICKS(PL),
        .STARTUP_TICKS(3), .DETECT_TICKS(2), .TICK_CYCLES(TC)
    ) prt_reset_timer_i (
        .pclk, .presetn, .clk_en, .supply_valid, .button_in_a, .button_in_b, .hold_time_select,
        .reset_out, .reset_oe, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
    );
    prt_button_model prt_button_model_i (
        .pclk, .reset_oe, .button_in_a, .button_in_b, .hold_time_select, .sys_reset_n
    );
    // Compares one value and keeps the tallies.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One APB transfer; read data is taken at the edge that sees pready.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge pclk);
        end
        if (k >= 20) n_mismatch++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Short hand for the button model.
    task automatic btn(input logic a, input logic b);
        prt_button_model_i.press(a, b);
    endtask : btn
    // Waits for the enable level; running out of time is a mismatch.
    task automatic wait_oe(input logic v, input int lim);
        t = 0;
        while (reset_oe !== v && t < lim) begin
            @(posedge pclk);
            t++;
        end
        chk("oe level", 32'(reset_oe), 32'(v));
    endtask : wait_oe
    // Presses both buttons; tick phase gives one tick of slack.
    task automatic hold(input int n);
        btn(1'b0, 1'b0);
        wait_oe(1'b1, (n + 4) * TC);
        chk("hold time", 32'(t >= (n - 1) * TC && t <= (n + 1) * TC + 4), w1);
    endtask : hold
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    // Cuts a hung run short well after the tests should have ended.
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        give_verdict();
    end
    // ----------------
    // Tests
    // ----------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, w0);
        chk("ctrl reset", rd, w1);
        apb(1'b0, 12'h010, w0);
        chk("unmapped", {rd[30:0], pslverr}, w1);
        $display("test registers done");
        btn(1'b0, 1'b0);
        repeat (40) @(posedge pclk);
        chk("no supply", 32'(reset_oe), w0);
        supply_valid <= 1'b1;
        repeat (2 * TC) @(posedge pclk);
        chk("start-up", 32'(reset_oe), w0);
        btn(1'b1, 1'b1);
        repeat (4 * TC) @(posedge pclk);
        apb(1'b1, 12'h00c, w0);
        $display("test power-up done");
        hold(HI);
        btn(1'b1, 1'b0);
        btn(1'b0, 1'b0);
        wait_oe(1'b0, (PL + 2) * TC);
        chk("pulse", 32'(t + 2 >= (PL - 1) * TC && t + 2 <= (PL + 1) * TC + 2), w1);
        repeat (3 * HI * TC) @(posedge pclk);
        chk("single shot", 32'(reset_oe), w0);
        $display("test hold and pulse done");
        btn(1'b1, 1'b0);
        btn(1'b0, 1'b0);
        repeat ((HI - 2) * TC) @(posedge pclk);
        btn(1'b0, 1'b1);
        hold(HI);
        btn(1'b1, 1'b0);
        wait_oe(1'b0, (PL + 2) * TC);
        hold(HI);
        btn(1'b1, 1'b1);
        wait_oe(1'b0, (PL + 2) * TC);
        $display("test re-arm done");
        prt_button_model_i.strap(1'b0, 1'b0);
        btn(1'b0, 1'b0);
        repeat (4 * TC) @(posedge pclk);
        prt_button_model_i.strap(1'b1, 1'b1);
        wait_oe(1'b1, (LO + 4) * TC);
        t = t + 4 * TC + 1;
        chk("long hold", 32'(t >= (LO - 1) * TC && t <= (LO + 1) * TC + 4), w1);
        chk("line low", {30'h0, sys_reset_n, reset_out}, w0);
        btn(1'b1, 1'b1);
        wait_oe(1'b0, (PL + 2) * TC);
        $display("test strap done");
        apb(1'b1, 12'h000, w0);
        btn(1'b0, 1'b0);
        repeat ((HI + 3) * TC) @(posedge pclk);
        chk("disabled", 32'(reset_oe), w0);
        apb(1'b0, 12'h004, w0);
        chk("state off", 32'(rd[2:0]), 32'(prt_pkg::ST_OFF));
        btn(1'b1, 1'b1);
        apb(1'b1, 12'h000, w1);
        apb(1'b0, 12'h00c, w0);
        chk("events", rd, 32'h4);
        $display("test register control done");
        give_verdict();
    end
endmodule : tb_prt_reset_timer
